// ---- bench/i2css_master_model.sv ----
/* Behavioural I2C bus master driving open-drain pull-low enables.
   Assumes the bench resolves both lines with pull-ups. */
`timescale 1ns/1ps
module i2css_master_model (
    input wire clk,
    input wire scl,
    input wire sda,
    output reg scl_low,
    output reg sda_low
);
    integer n;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task tick(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask
    // A released clock counts as high only once the slave stops holding it.
    task scl_up;
        begin
            scl_low = 1'b0;
            n = 0;
            while (scl !== 1'b1 && n < 4000) begin
                tick(1);
                n = n + 1;
            end
            tick(6);
        end
    endtask
    task start;
        begin
            sda_low = 1'b0;
            tick(6);
            scl_up;
            sda_low = 1'b1;
            tick(6);
            scl_low = 1'b1;
            tick(6);
        end
    endtask
    task stop;
        begin
            sda_low = 1'b1;
            tick(6);
            scl_up;
            sda_low = 1'b0;
            tick(6);
        end
    endtask
    task clk_bit(input b, output r);
        begin
            sda_low = !b;
            tick(6);
            scl_up;
            r = sda;
            scl_low = 1'b1;
            tick(6);
        end
    endtask
    task wbyte(input [7:0] b, output ack_n);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                clk_bit(b[i], r);
            clk_bit(1'b1, ack_n);
        end
    endtask
    task rbyte(input ack_n, output [7:0] b);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                clk_bit(1'b1, r);
                b[i] = r;
            end
            clk_bit(ack_n, r);
        end
    endtask
endmodule

// ---- bench/i2css_slave_monitor.sv ----
/* Bound checker for the I2C slave state handler.
   Assumes it sees only the ports of i2css_slave, one clock domain. */
`timescale 1ns/1ps
module i2css_slave_monitor (
    input wire       clk,
    input wire       rstn,
    input wire       scl_oe_q,
    input wire       si_clear,
    input wire       si_q,
    input wire [7:0] status_q,
    input wire       start_issue_q,
    input wire       bus_busy_q,
    input wire       slave_receive_state,
    input wire       slave_transmit_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_event(code);
        $rose(si_q) && status_q == code;
    endsequence
    property p_gc_nack;
        s_event(8'h98) |-> $past(status_q) inside {8'h70, 8'h78, 8'h90};
    endproperty
    a_gc_nack: assert property (p_gc_nack)
        else $error("0x98 without general call");
    property p_stop_addr;
        s_event(8'ha0) |-> $past(slave_receive_state) ||
            $past(slave_transmit_state);
    endproperty
    a_stop_addr: assert property (p_stop_addr)
        else $error("0xa0 while not addressed");
    property p_a0_free;
        si_q && status_q == 8'ha0 |-> !scl_oe_q;
    endproperty
    a_a0_free: assert property (p_a0_free)
        else $error("clock held on 0xa0");
    property p_write_rx;
        $rose(si_q) && status_q inside {8'h60, 8'h68, 8'h70, 8'h78}
            |-> !slave_transmit_state;
    endproperty
    a_write_rx: assert property (p_write_rx)
        else $error("transmit state on write address");
    property p_read_flag;
        $changed(status_q) && status_q inside {8'ha8, 8'hb0} |-> si_q;
    endproperty
    a_read_flag: assert property (p_read_flag)
        else $error("read status without flag");
    // Stretching starts one cycle after the flag, so two flag cycles are
    // needed before the clock must be held.
    property p_hold;
        si_q && $past(si_q) && status_q != 8'ha0 |-> scl_oe_q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("clock not held while flag set");
    property p_si_clear;
        si_q && si_clear |=> !si_q;
    endproperty
    a_si_clear: assert property (p_si_clear)
        else $error("flag not cleared");
    property p_ignore;
        !si_q && !$past(si_q) && status_q inside {8'hc0, 8'hc8}
            |-> !scl_oe_q;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("clock held after last byte");
    property p_start_pulse;
        start_issue_q |-> !bus_busy_q ##1 !start_issue_q;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start issued on busy bus");
endmodule

bind i2css_slave i2css_slave_monitor u_mon (
    .clk(clk), .rstn(rstn), .scl_oe_q(scl_oe_q), .si_clear(si_clear),
    .si_q(si_q), .status_q(status_q), .start_issue_q(start_issue_q),
    .bus_busy_q(bus_busy_q),
    .slave_receive_state(slave_receive_state),
    .slave_transmit_state(slave_transmit_state)
);

// ---- bench/i2css_slave_test.sv ----
/* Self-checking bench for the I2C slave state handler.
   Assumes the master model and the bound monitor are compiled first. */
`timescale 1ns/1ps
module i2css_slave_test;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg  [7:0] own_adr = 8'h55;
    reg        ack_en = 1'b1;
    reg        start_request = 1'b0;
    reg        arb_lost = 1'b0;
    reg        si_clear = 1'b0;
    reg  [7:0] tx_data = 8'h00;
    reg        tx_valid = 1'b0;
    wire       scl_oe, scl_o, sda_oe, sda_o, m_scl_low, m_sda_low;
    wire       si_q, start_issue, busy, rx_state, tx_state;
    wire       tx_ready, rx_valid;
    wire [7:0] status_q, rx_data;
    wire       scl = !(m_scl_low || (scl_oe && !scl_o));
    wire       sda = !(m_sda_low || (sda_oe && !sda_o));
    integer    miscompares = 0;
    integer    check_count = 0;
    integer    rx_pulses = 0;
    integer    i, n;
    reg        ack_n, seen;
    reg  [7:0] rb;

    always #12.5 clk = !clk;

    // The received-byte strobe stands one cycle only, so it is counted here.
    always @(posedge clk) begin
        if (rx_valid === 1'b1) rx_pulses <= rx_pulses + 1;
    end

    i2css_slave uut (.clk(clk), .rstn(rstn), .scl_i(scl), .scl_o_q(scl_o),
        .scl_oe_q(scl_oe), .sda_i(sda), .sda_o_q(sda_o), .sda_oe_q(sda_oe),
        .own_slave_address(own_adr), .acknowledge_assert(ack_en),
        .start_request(start_request), .arb_lost(arb_lost),
        .si_clear(si_clear), .si_q(si_q), .status_q(status_q),
        .start_issue_q(start_issue), .bus_busy_q(busy),
        .slave_receive_state(rx_state), .slave_transmit_state(tx_state),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data_q(rx_data), .rx_valid_q(rx_valid));
    i2css_master_model mm (.clk(clk), .scl(scl), .sda(sda),
        .scl_low(m_scl_low), .sda_low(m_sda_low));

    task check_byte(input [63:0] what, input [7:0] exp, input [7:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task check_bit(input [63:0] what, input exp, input got);
        check_byte(what, {7'h00, exp}, {7'h00, got});
    endtask
    task step(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask
    task event_code(input [7:0] code);
        begin
            n = 0;
            while (si_q !== 1'b1 && n < 5000) begin
                step(1);
                n = n + 1;
            end
            check_byte("status", code, status_q);
        end
    endtask
    task clear_si;
        begin
            si_clear = 1'b1;
            step(1);
            si_clear = 1'b0;
            step(2);
        end
    endtask
    task push(input [7:0] b);
        begin
            tx_data = b;
            tx_valid = 1'b1;
            n = 0;
            while (tx_ready !== 1'b1 && n < 50) begin
                step(1);
                n = n + 1;
            end
            step(1);
            tx_valid = 1'b0;
            step(1);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d miscompares %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        miscompares = miscompares + 1;
        final_report;
    end

    initial begin
        step(8);
        rstn = 1'b1;
        step(2);
        check_byte("status", 8'hf8, status_q);
        mm.start;
        check_bit("busy", 1'b1, busy);
        mm.wbyte(8'h54, ack_n);
        event_code(8'h60);
        check_bit("tx_state", 1'b0, tx_state);
        clear_si;
        mm.stop;
        event_code(8'ha0);
        clear_si;
        check_bit("rx_state", 1'b0, rx_state);
        mm.start;
        mm.wbyte(8'h00, ack_n);
        event_code(8'h70);
        ack_en = 1'b0;
        clear_si;
        mm.wbyte(8'h3c, ack_n);
        check_bit("ack", 1'b1, ack_n);
        event_code(8'h98);
        check_byte("rx_data", 8'h3c, rx_data);
        check_byte("rx_valid", 8'h01, rx_pulses[7:0]);
        start_request = 1'b1;
        clear_si;
        seen = 1'b0;
        fork
            mm.stop;
            repeat (40) begin
                step(1);
                if (start_issue === 1'b1) seen = 1'b1;
            end
        join
        check_bit("start", 1'b1, seen);
        start_request = 1'b0;
        mm.start;
        mm.wbyte(8'h54, ack_n);
        check_bit("ack", 1'b1, ack_n);
        check_bit("si", 1'b0, si_q);
        ack_en = 1'b1;
        mm.start;
        mm.wbyte(8'h54, ack_n);
        event_code(8'h60);
        clear_si;
        mm.start;
        event_code(8'ha0);
        clear_si;
        mm.stop;
        own_adr = 8'h54;
        mm.start;
        mm.wbyte(8'h00, ack_n);
        check_bit("ack", 1'b1, ack_n);
        mm.stop;
        own_adr = 8'h55;
        for (i = 0; i < 17; i = i + 1)
            push(8'h30 + i[7:0]);
        step(2);
        check_bit("tx_ready", 1'b0, tx_ready);
        mm.start;
        mm.wbyte(8'h55, ack_n);
        event_code(8'ha8);
        for (i = 0; i < 17; i = i + 1) begin
            if (i == 16) ack_en = 1'b0;
            clear_si;
            mm.rbyte(1'b0, rb);
            check_byte("rd_data", 8'h30 + i[7:0], rb);
            event_code(i == 16 ? 8'hc8 : 8'hb8);
        end
        clear_si;
        mm.rbyte(1'b1, rb);
        check_byte("rd_data", 8'hff, rb);
        check_bit("si", 1'b0, si_q);
        mm.stop;
        ack_en = 1'b1;
        check_bit("tx_ready", 1'b1, tx_ready);
        arb_lost = 1'b1;
        step(1);
        arb_lost = 1'b0;
        mm.start;
        mm.wbyte(8'h55, ack_n);
        event_code(8'hb0);
        clear_si;
        mm.rbyte(1'b1, rb);
        check_byte("rd_data", 8'hff, rb);
        event_code(8'hc0);
        clear_si;
        mm.stop;
        final_report;
    end
endmodule

// ---- core/i2css_defines.vh ----
/*
 * Shared constants of the I2C slave state handler: status codes, the
 * general call address, byte framing and the transmit FIFO shape.
 * Assumes it is included by bare name from the core/ design files.
 */
`ifndef I2CSS_DEFINES_VH
`define I2CSS_DEFINES_VH

`define I2CSS_DATA_W        8
`define I2CSS_FIFO_DEPTH    16
`define I2CSS_BITS_PER_BYTE 4'h8
`define I2CSS_GC_ADDR       8'h00
`define I2CSS_IDLE_BYTE     8'hff

`define I2CSS_ST_NO_INFO    8'hf8
`define I2CSS_ST_SLA_W      8'h60
`define I2CSS_ST_AL_SLA_W   8'h68
`define I2CSS_ST_GC         8'h70
`define I2CSS_ST_AL_GC      8'h78
`define I2CSS_ST_DAT_ACK    8'h80
`define I2CSS_ST_DAT_NACK   8'h88
`define I2CSS_ST_GC_ACK     8'h90
`define I2CSS_ST_GC_NACK    8'h98
`define I2CSS_ST_STOP       8'ha0
`define I2CSS_ST_SLA_R      8'ha8
`define I2CSS_ST_AL_SLA_R   8'hb0
`define I2CSS_ST_TX_ACK     8'hb8
`define I2CSS_ST_TX_NACK    8'hc0
`define I2CSS_ST_TX_LAST    8'hc8

`endif

// ---- core/i2css_fifo.v ----
/*
 * Transmit data FIFO with valid/ready on both sides and registered read
 * data. Assumes DEPTH is a power of two and a synchronous active-low reset.
 * Holds DEPTH words in memory plus one in the output register.
 */
`timescale 1ns/1ps
module i2css_fifo #(
    parameter W     = 8,
    parameter DEPTH = 16
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output reg          in_ready_q,
    output reg  [W-1:0] out_data_q,
    output reg          out_valid_q,
    input  wire         out_ready
);
    localparam AW = $clog2(DEPTH);
    localparam [AW:0] FULL = DEPTH[AW:0];

    reg  [W-1:0]  mem [0:DEPTH-1];
    reg  [AW-1:0] wp_q;
    reg  [AW-1:0] rp_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;
    wire [AW:0]   cnt_d;

    assign push  = in_valid & in_ready_q;
    assign pop   = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);
    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            wp_q        <= {AW{1'b0}};
            rp_q        <= {AW{1'b0}};
            cnt_q       <= {(AW+1){1'b0}};
            in_ready_q  <= 1'b0;
            out_data_q  <= {W{1'b0}};
            out_valid_q <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            in_ready_q <= (cnt_d != FULL);
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                out_data_q  <= mem[rp_q];
                out_valid_q <= 1'b1;
                rp_q        <= rp_q + 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule

// ---- core/i2css_slave.v ----
/*
 * Slave side of an I2C controller: address recognition, slave receive and
 * slave transmit byte handling, status reporting with a serial event flag,
 * and the return to the not-addressed state. Assumes SCL and SDA arrive
 * already synchronous to clk, SCL far slower than clk, and an outside
 * master block that pulses arb_lost and acts on start_issue_q.
 */
`timescale 1ns/1ps
`include "i2css_defines.vh"

// Behaviour
// - General-call data answered NOT ACK reports 0x98, then leaves addressed.
// - STOP or repeated START while addressed reports 0xA0, then not addressed.
// - Leaving with acknowledge off recognises neither own nor general call.
// - Leaving with acknowledge on recognises own address, general call if bit0.
// - Start request set on leaving issues START once the bus is free.
// - Slave transmit entered only on own address with read bit one.
// - Own address with read sets event flag and a valid status.
// - Addressed for read after lost arbitration reports 0xB0, transmits.
// - Acknowledge cleared while transmitting: one last byte, then 0xC0/0xC8.
// - After last byte ignore further clocks so master reads all ones.
// - Acknowledge cleared: no answer to own or general call address.
// - Acknowledge cleared: bus still watched; recognition resumes when set.
module i2css_slave #(
    parameter DW    = `I2CSS_DATA_W,
    parameter DEPTH = `I2CSS_FIFO_DEPTH
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire          scl_i,
    output reg           scl_o_q,
    output reg           scl_oe_q,
    input  wire          sda_i,
    output reg           sda_o_q,
    output reg           sda_oe_q,
    input  wire [7:0]    own_slave_address,
    input  wire          acknowledge_assert,
    input  wire          start_request,
    input  wire          arb_lost,
    input  wire          si_clear,
    output reg           si_q,
    output reg  [7:0]    status_q,
    output reg           start_issue_q,
    output reg           bus_busy_q,
    output reg           slave_receive_state,
    output reg           slave_transmit_state,
    input  wire [DW-1:0] tx_data,
    input  wire          tx_valid,
    output wire          tx_ready,
    output reg  [7:0]    rx_data_q,
    output reg           rx_valid_q
);
    localparam [8:0] S_IDLE   = 9'h001;
    localparam [8:0] S_ADDR   = 9'h002;
    localparam [8:0] S_RX     = 9'h004;
    localparam [8:0] S_ACK    = 9'h008;
    localparam [8:0] S_TX     = 9'h010;
    localparam [8:0] S_RACK   = 9'h020;
    localparam [8:0] S_HOLD   = 9'h040;
    localparam [8:0] S_IGNORE = 9'h080;
    localparam [8:0] S_SPARE  = 9'h100;

    reg  [8:0]    state_q;
    reg  [8:0]    after_q;
    reg  [3:0]    cnt_q;
    reg  [7:0]    shift_q;
    reg           scl_q;
    reg           sda_q;
    reg           gc_q;
    reg           read_q;
    reg           phase_q;
    reg           ack_q;
    reg           nack_q;
    reg           last_q;
    reg           arb_q;
    reg           stretch_q;
    reg           start_pend_q;
    reg           sda_oe_d;
    reg           scl_oe_d;
    wire          scl_rise;
    wire          scl_fall;
    wire          start_cond;
    wire          stop_cond;
    wire          addressed;
    wire          hit_own;
    wire          hit_gc;
    wire          load_tx;
    wire [DW-1:0] fifo_data;
    wire          fifo_valid;

    // Status code of a received data byte, by addressing kind and answer.
    function [7:0] rx_status;
        input gc;
        input ack;
        begin
            if (gc) begin
                rx_status = ack ? `I2CSS_ST_GC_ACK : `I2CSS_ST_GC_NACK;
            end else begin
                rx_status = ack ? `I2CSS_ST_DAT_ACK : `I2CSS_ST_DAT_NACK;
            end
        end
    endfunction

    assign scl_rise   = scl_i & ~scl_q;
    assign scl_fall   = ~scl_i & scl_q;
    assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_cond  = scl_i & scl_q & ~sda_q & sda_i;
    assign addressed  = (state_q == S_RX) | (state_q == S_ACK) |
                        (state_q == S_TX) | (state_q == S_RACK);
    // Recognition follows the live acknowledge bit, so clearing it isolates
    // the block at the next address while the bus is still watched.
    assign hit_own = acknowledge_assert &
                     (shift_q[7:1] == own_slave_address[7:1]);
    assign hit_gc  = acknowledge_assert & own_slave_address[0] &
                     (shift_q == `I2CSS_GC_ADDR);
    assign load_tx = (state_q == S_HOLD) & ~si_q & (after_q == S_TX);

    i2css_fifo #(
        .W     (DW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk         (clk),
        .rstn        (rstn),
        .in_data     (tx_data),
        .in_valid    (tx_valid),
        .in_ready_q  (tx_ready),
        .out_data_q  (fifo_data),
        .out_valid_q (fifo_valid),
        .out_ready   (load_tx)
    );

    always @* begin
        sda_oe_d = ((state_q == S_ACK) & ack_q) |
                   ((state_q == S_TX) & ~shift_q[7]);
        // Stretching the low phase is what holds the master off.
        scl_oe_d = (state_q == S_HOLD) & stretch_q & si_q;
    end

    always @(posedge clk) begin
        if (!rstn) begin
            state_q              <= S_IDLE;
            after_q              <= S_IDLE;
            cnt_q                <= 4'h0;
            shift_q              <= 8'h00;
            scl_q                <= 1'b1;
            sda_q                <= 1'b1;
            gc_q                 <= 1'b0;
            read_q               <= 1'b0;
            phase_q              <= 1'b0;
            ack_q                <= 1'b0;
            nack_q               <= 1'b0;
            last_q               <= 1'b0;
            arb_q                <= 1'b0;
            stretch_q            <= 1'b0;
            start_pend_q         <= 1'b0;
            start_issue_q        <= 1'b0;
            bus_busy_q           <= 1'b0;
            si_q                 <= 1'b0;
            status_q             <= `I2CSS_ST_NO_INFO;
            rx_data_q            <= 8'h00;
            rx_valid_q           <= 1'b0;
            scl_o_q              <= 1'b0;
            scl_oe_q             <= 1'b0;
            sda_o_q              <= 1'b0;
            sda_oe_q             <= 1'b0;
            slave_receive_state  <= 1'b0;
            slave_transmit_state <= 1'b0;
        end else begin
            scl_q         <= scl_i;
            sda_q         <= sda_i;
            sda_oe_q      <= sda_oe_d;
            scl_oe_q      <= scl_oe_d;
            rx_valid_q    <= 1'b0;
            start_issue_q <= 1'b0;
            slave_receive_state  <= (state_q == S_RX) |
                                    ((state_q == S_ACK) & ~read_q);
            slave_transmit_state <= (state_q == S_TX) | (state_q == S_RACK) |
                                    ((state_q == S_ACK) & read_q);
            if (start_cond) begin
                bus_busy_q <= 1'b1;
            end else if (stop_cond) begin
                bus_busy_q <= 1'b0;
            end
            if (arb_lost) begin
                arb_q <= 1'b1;
            end
            if (start_pend_q & ~bus_busy_q) begin
                start_issue_q <= 1'b1;
                start_pend_q  <= 1'b0;
            end
            // A set later in this block overrides this clear.
            if (si_clear) begin
                si_q <= 1'b0;
            end
            if (addressed & (start_cond | stop_cond)) begin
                status_q  <= `I2CSS_ST_STOP;
                si_q      <= 1'b1;
                stretch_q <= 1'b0;
                after_q   <= S_IDLE;
                state_q   <= S_HOLD;
            end else begin
                case (state_q)
                    S_IDLE, S_IGNORE: begin
                        // Clocks of a continued read are not answered here.
                        if (start_cond) begin
                            cnt_q   <= 4'h0;
                            state_q <= S_ADDR;
                        end else if (stop_cond) begin
                            state_q <= S_IDLE;
                        end
                    end
                    S_ADDR: begin
                        if (stop_cond) begin
                            state_q <= S_IDLE;
                        end else if (start_cond) begin
                            cnt_q <= 4'h0;
                        end else if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_i};
                            cnt_q   <= cnt_q + 4'h1;
                        end else if (scl_fall &&
                                     cnt_q == `I2CSS_BITS_PER_BYTE) begin
                            if (hit_own | hit_gc) begin
                                ack_q   <= 1'b1;
                                gc_q    <= hit_gc & ~hit_own;
                                read_q  <= hit_own & shift_q[0];
                                phase_q <= 1'b1;
                                state_q <= S_ACK;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_i};
                            cnt_q   <= cnt_q + 4'h1;
                        end else if (scl_fall &&
                                     cnt_q == `I2CSS_BITS_PER_BYTE) begin
                            ack_q   <= acknowledge_assert;
                            state_q <= S_ACK;
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            si_q      <= 1'b1;
                            stretch_q <= 1'b1;
                            cnt_q     <= 4'h0;
                            phase_q   <= 1'b0;
                            state_q   <= S_HOLD;
                            if (phase_q) begin
                                arb_q <= 1'b0;
                                if (read_q) begin
                                    status_q <= arb_q ? `I2CSS_ST_AL_SLA_R
                                                      : `I2CSS_ST_SLA_R;
                                    after_q  <= S_TX;
                                end else begin
                                    if (gc_q) begin
                                        status_q <= arb_q ? `I2CSS_ST_AL_GC
                                                          : `I2CSS_ST_GC;
                                    end else begin
                                        status_q <= arb_q ? `I2CSS_ST_AL_SLA_W
                                                          : `I2CSS_ST_SLA_W;
                                    end
                                    after_q <= S_RX;
                                end
                            end else begin
                                rx_data_q  <= shift_q;
                                rx_valid_q <= 1'b1;
                                status_q   <= rx_status(gc_q, ack_q);
                                after_q    <= ack_q ? S_RX : S_IDLE;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_q == `I2CSS_BITS_PER_BYTE) begin
                                state_q <= S_RACK;
                            end else begin
                                shift_q <= {shift_q[6:0], 1'b1};
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_i;
                        end else if (scl_fall) begin
                            si_q      <= 1'b1;
                            stretch_q <= 1'b1;
                            state_q   <= S_HOLD;
                            if (nack_q) begin
                                status_q <= `I2CSS_ST_TX_NACK;
                                after_q  <= S_IDLE;
                            end else if (last_q) begin
                                status_q <= `I2CSS_ST_TX_LAST;
                                after_q  <= S_IGNORE;
                            end else begin
                                status_q <= `I2CSS_ST_TX_ACK;
                                after_q  <= S_TX;
                            end
                        end
                    end
                    S_HOLD: begin
                        // Nothing moves on the bus side until the flag drops.
                        if (~si_q) begin
                            state_q   <= after_q;
                            stretch_q <= 1'b0;
                            cnt_q     <= 4'h0;
                            if (after_q == S_TX) begin
                                shift_q <= fifo_valid ? fifo_data[7:0]
                                                      : `I2CSS_IDLE_BYTE;
                                last_q  <= ~acknowledge_assert;
                            end
                            if ((after_q == S_IDLE || after_q == S_IGNORE) &&
                                start_request) begin
                                start_pend_q <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
